/* core/apd_pkg.sv */
package apd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SECTOR_COUNT = 8'h00;
  localparam logic [7:0] OFS_SECTOR_NUMBER = 8'h04;
  localparam logic [7:0] OFS_CYL = 8'h08;
  localparam logic [7:0] OFS_HEAD = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_PWR = 8'h20;
  // status and control bit positions
  localparam int STAT_BSY = 7;
  localparam int STAT_DRDY = 6;
  localparam int STAT_DRQ = 3;
  localparam int STAT_ERR = 0;
  localparam int CTRL_SRST = 2;
  // opcodes, check power mode results and sector word counts
  localparam logic [6:0] OP_WDMA_HI = 7'h65;
  localparam logic [7:0] OP_RDBUF = 8'he4;
  localparam logic [7:0] OP_WRBUF = 8'he8;
  localparam logic [7:0] CHK_IDLE = 8'hff;
  localparam logic [7:0] CHK_STBY = 8'h00;
  localparam logic [7:0] WORD_LAST = 8'hff;
  localparam int SECT_WORDS = 256;
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_S = 1;
  localparam logic [11:0] STBY_UNIT_S = 12'h005;
  localparam int unsigned STBY_DEF_MIN = 45;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam logic [11:0] STBY_DEF_S = 12'(STBY_DEF_MIN * SEC_PER_MIN);

  typedef enum logic [2:0] {
    ST_READY = 3'b000, ST_SPIN = 3'b001, ST_DMA = 3'b010,
    ST_SECT = 3'b011, ST_BUFPREP = 3'b100, ST_PIO = 3'b101
  } apd_state_t;
  typedef enum logic [1:0] {
    PM_IDLE = 2'b00, PM_STBY = 2'b01, PM_SLEEP = 2'b10
  } apd_pmode_t;
  typedef enum logic [2:0] {
    PC_NONE = 3'b000, PC_SBI = 3'b001, PC_IDI = 3'b010, PC_SB = 3'b011,
    PC_ID = 3'b100, PC_CHK = 3'b101, PC_SLP = 3'b110
  } apd_pcmd_t;

  typedef struct packed {
    logic [3:0] head;
    logic [15:0] cyl;
    logic [7:0] sector_number_field;
    logic [7:0] sector_count_field;
  } apd_tf_t;
  typedef struct packed {
    logic ack;
    logic wr;
    logic [15:0] data;
  } apd_dma_t;
endpackage : apd_pkg

/* core/apd_core.sv */
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - DMA write moves each sector after the device raises its DMA request.
// - DMA write raises one interrupt only, at command completion.
// - busy or data request stays set during the whole DMA phase.
// - normal end leaves address at last sector and count at zero.
// - unrecoverable error ends command with address at failing sector.
// - power opcodes decode into six sub-commands, two opcodes each.
// - three power modes; idle is re-entered after every disk access.
// - auto-standby period is count times five seconds, zero is 45 min.
// - disk access in standby spins up first, then runs.
// - power-up enters idle with 45 minute auto-standby enabled.
// - ready bit stays set and commands accepted in idle and standby.
// - standby immediate interrupts at once; no-op if already standby.
// - idle immediate restarts timer, interrupts after idle entered.
// - standby command enters standby and enables timer from count.
// - idle command enters idle, enables timer; expiry goes standby.
// - access that woke the drive reloads and restarts the timer.
// - check power mode returns zero for standby, all ones for idle.
// - sleep enters at once, interrupts; only reset wakes to standby.
// - read buffer: busy, then request set, interrupt, one sector read.
// - write buffer: request set, host writes one sector of words.
module apd_core import apd_pkg::*; #(
  parameter int unsigned SEC_CYCLES = CLK_HZ * TICK_S
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire apd_dma_t dma_in,
  output logic dmarq,
  input wire logic spin_ready,
  input wire logic disk_err,
  output logic spindle_on,
  output logic intrq
);
  localparam int DIVW = $clog2(SEC_CYCLES + 1);

  function automatic apd_pcmd_t pwr_dec(input logic [7:0] op);
    unique case (op)
      8'he0, 8'h94: pwr_dec = PC_SBI;
      8'he1, 8'h95: pwr_dec = PC_IDI;
      8'he2, 8'h96: pwr_dec = PC_SB;
      8'he3, 8'h97: pwr_dec = PC_ID;
      8'he5, 8'h98: pwr_dec = PC_CHK;
      8'he6, 8'h99: pwr_dec = PC_SLP;
      default: pwr_dec = PC_NONE;
    endcase
  endfunction : pwr_dec

  function automatic logic [11:0] stby_secs(input logic [7:0] n);
    stby_secs = (n == 8'h00) ? STBY_DEF_S : 12'(n) * STBY_UNIT_S;
  endfunction : stby_secs

  apd_state_t st_r;
  apd_pmode_t pm_r;
  apd_tf_t tf_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, dmarq_r, spindle_r, intrq_r;
  logic bsy_r, drq_r, err_r, pend_dma_r, pio_wr_r;
  logic [7:0] wcnt_r;
  logic [15:0] buf_mem [SECT_WORDS];
  logic [11:0] tmr_r, tmr_load_r;
  logic tmr_en_r, sec_tick_r;
  logic [DIVW-1:0] div_r;

  logic acc, wr, rd, cmd_go, go_wdma, go_rdb, go_wrb, drdy;
  logic sect_last, dma_end, spun_up, pwr_done, idle_now, irq_set;
  logic tmr_reload, tmr_expire, srst, pio_acc, dma_beat;
  logic [7:0] op;
  apd_pcmd_t pc;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dmarq = dmarq_r;
  assign spindle_on = spindle_r;
  assign intrq = intrq_r;

  always_comb begin
    acc = psel & penable & pready_r;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    op = pwdata[7:0];
    drdy = (pm_r != PM_SLEEP);
    // commands refused while busy, mid transfer or asleep
    cmd_go = wr && paddr == OFS_CMD && !bsy_r && !drq_r && drdy;
    go_wdma = cmd_go && op[7:1] == OP_WDMA_HI;
    go_rdb = cmd_go && op == OP_RDBUF;
    go_wrb = cmd_go && op == OP_WRBUF;
    pc = cmd_go ? pwr_dec(op) : PC_NONE;
    srst = wr && paddr == OFS_CTRL && pwdata[CTRL_SRST];
    sect_last = (tf_r.sector_count_field == 8'h01);
    dma_end = (st_r == ST_SECT) && (disk_err || sect_last);
    spun_up = (st_r == ST_SPIN) && spin_ready;
    pwr_done = spun_up && !pend_dma_r;
    idle_now = (pc == PC_IDI || pc == PC_ID) && pm_r == PM_IDLE;
    irq_set = dma_end || pwr_done || idle_now || (st_r == ST_BUFPREP)
      || pc == PC_SBI || pc == PC_SB || pc == PC_CHK || pc == PC_SLP;
    tmr_reload = cmd_go || dma_end || pwr_done;
    tmr_expire = sec_tick_r && pm_r == PM_IDLE && st_r == ST_READY
      && tmr_en_r && tmr_r == 12'h001 && !cmd_go;
    pio_acc = acc && paddr == OFS_DATA && st_r == ST_PIO
      && (pwrite == pio_wr_r);
    dma_beat = (st_r == ST_DMA) && dma_in.ack && dma_in.wr;
  end

  // apb slave: one wait state, reads captured as pready rises
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= 1'b0;
      if (psel & penable & ~pready_r) begin
        prdata_r <= 32'h0000_0000;
        unique case (paddr)
          OFS_SECTOR_COUNT: prdata_r[7:0] <= tf_r.sector_count_field;
          OFS_SECTOR_NUMBER: prdata_r[7:0] <= tf_r.sector_number_field;
          OFS_CYL: prdata_r[15:0] <= tf_r.cyl;
          OFS_HEAD: prdata_r[3:0] <= tf_r.head;
          OFS_STAT: begin
            prdata_r[STAT_BSY] <= bsy_r;
            prdata_r[STAT_DRDY] <= drdy;
            prdata_r[STAT_DRQ] <= drq_r;
            prdata_r[STAT_ERR] <= err_r;
          end
          OFS_DATA: prdata_r[15:0] <= buf_mem[wcnt_r];
          OFS_PWR: prdata_r[15:0] <= {tmr_en_r, 1'b0, pm_r, tmr_r};
          OFS_CMD, OFS_CTRL: prdata_r <= 32'h0000_0000;
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // second tick for the auto-standby countdown
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= '0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= (div_r == DIVW'(SEC_CYCLES - 1));
      div_r <= (div_r == DIVW'(SEC_CYCLES - 1)) ? '0 : div_r + 1'b1;
    end
  end

  // auto-standby timer in seconds; only counts in idle with no command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr_en_r <= 1'b1;
      tmr_load_r <= STBY_DEF_S;
      tmr_r <= STBY_DEF_S;
    end else if (pc == PC_SB || pc == PC_ID) begin
      tmr_en_r <= 1'b1;
      tmr_load_r <= stby_secs(tf_r.sector_count_field);
      tmr_r <= stby_secs(tf_r.sector_count_field);
    end else if (tmr_reload) begin
      tmr_r <= tmr_load_r;
    end else if (sec_tick_r && pm_r == PM_IDLE && tmr_en_r
                 && st_r == ST_READY && tmr_r != 12'h000) begin
      tmr_r <= tmr_r - 12'h001;
    end
  end

  // power mode and spindle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pm_r <= PM_IDLE;
      spindle_r <= 1'b1;
    end else if (srst && pm_r == PM_SLEEP) begin
      pm_r <= PM_STBY;
      spindle_r <= 1'b0;
    end else if (pc == PC_SLP) begin
      pm_r <= PM_SLEEP;
      spindle_r <= 1'b0;
    end else if (pc == PC_SBI || pc == PC_SB) begin
      // spindle is switched off on the same edge that raises the interrupt
      pm_r <= PM_STBY;
      spindle_r <= 1'b0;
    end else if ((go_wdma || pc == PC_IDI || pc == PC_ID)
                 && pm_r != PM_IDLE) begin
      spindle_r <= 1'b1;
    end else if (spun_up || dma_end) begin
      pm_r <= PM_IDLE;
    end else if (tmr_expire) begin
      pm_r <= PM_STBY;
      spindle_r <= 1'b0;
    end
  end

  // command sequencer and status bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_READY;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      dmarq_r <= 1'b0;
      pend_dma_r <= 1'b0;
      pio_wr_r <= 1'b0;
      wcnt_r <= 8'h00;
    end else begin
      unique case (st_r)
        ST_READY: begin
          if (cmd_go) begin
            err_r <= 1'b0;
            wcnt_r <= 8'h00;
          end
          if (go_wdma && pm_r != PM_IDLE) begin
            bsy_r <= 1'b1;
            pend_dma_r <= 1'b1;
            st_r <= ST_SPIN;
          end else if (go_wdma) begin
            bsy_r <= 1'b1;
            drq_r <= 1'b1;
            dmarq_r <= 1'b1;
            st_r <= ST_DMA;
          end else if ((pc == PC_IDI || pc == PC_ID) && !idle_now) begin
            bsy_r <= 1'b1;
            pend_dma_r <= 1'b0;
            st_r <= ST_SPIN;
          end else if (go_rdb) begin
            bsy_r <= 1'b1;
            pio_wr_r <= 1'b0;
            st_r <= ST_BUFPREP;
          end else if (go_wrb) begin
            drq_r <= 1'b1;
            pio_wr_r <= 1'b1;
            st_r <= ST_PIO;
          end
        end
        ST_SPIN: begin
          if (spin_ready && pend_dma_r) begin
            drq_r <= 1'b1;
            dmarq_r <= 1'b1;
            st_r <= ST_DMA;
          end else if (spin_ready) begin
            bsy_r <= 1'b0;
            st_r <= ST_READY;
          end
        end
        ST_DMA: begin
          if (dma_beat) begin
            wcnt_r <= wcnt_r + 8'h01;
            if (wcnt_r == WORD_LAST) begin
              dmarq_r <= 1'b0;
              drq_r <= 1'b0; // bsy still high
              st_r <= ST_SECT;
            end
          end
        end
        ST_SECT: begin
          if (dma_end) begin
            bsy_r <= 1'b0;
            err_r <= disk_err;
            st_r <= ST_READY;
          end else begin
            drq_r <= 1'b1;
            dmarq_r <= 1'b1;
            st_r <= ST_DMA;
          end
        end
        ST_BUFPREP: begin
          bsy_r <= 1'b0;
          drq_r <= 1'b1;
          st_r <= ST_PIO;
        end
        ST_PIO: begin
          // the host may stop early; the sector window stays open
          if (pio_acc) begin
            wcnt_r <= wcnt_r + 8'h01;
            if (wcnt_r == WORD_LAST) begin
              drq_r <= 1'b0;
              st_r <= ST_READY;
            end
          end
        end
        default: st_r <= ST_READY;
      endcase
    end
  end

  // one sector of buffer, shared by dma and pio writes
  always_ff @(posedge clk_sys) begin
    if (dma_beat) begin
      buf_mem[wcnt_r] <= dma_in.data;
    end else if (pio_acc && pio_wr_r) begin
      buf_mem[wcnt_r] <= pwdata[15:0];
    end
  end

  // task file: host writes when idle, sequencer updates on progress
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tf_r <= '0;
    end else if (pc == PC_CHK) begin
      tf_r.sector_count_field <= (pm_r == PM_IDLE) ? CHK_IDLE
        : CHK_STBY;
    end else if (st_r == ST_SECT && !disk_err) begin
      tf_r.sector_count_field <= tf_r.sector_count_field - 8'h01;
      if (!sect_last) begin
        {tf_r.cyl, tf_r.sector_number_field} <=
          {tf_r.cyl, tf_r.sector_number_field} + 24'h00_0001;
      end
    end else if ((go_rdb || go_wrb)) begin
      tf_r.sector_count_field <= 8'h00;
    end else if (wr && !bsy_r && !drq_r) begin
      unique case (paddr)
        OFS_SECTOR_COUNT: tf_r.sector_count_field <= pwdata[7:0];
        OFS_SECTOR_NUMBER: tf_r.sector_number_field <= pwdata[7:0];
        OFS_CYL: tf_r.cyl <= pwdata[15:0];
        OFS_HEAD: tf_r.head <= pwdata[3:0];
        default: tf_r <= tf_r;
      endcase
    end
  end

  // interrupt: set by events, cleared by a status read; set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intrq_r <= 1'b0;
    end else if (irq_set) begin
      intrq_r <= 1'b1;
    end else if (rd && paddr == OFS_STAT) begin
      intrq_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_dma_busy_drq: assert property (
    (st_r == ST_DMA || st_r == ST_SECT) |-> (bsy_r || drq_r))
    else $error("busy and data request both low in dma phase");
  chk_dmarq_only_dma: assert property (
    dmarq_r |-> (st_r == ST_DMA && drq_r))
    else $error("dma request outside dma state");
  chk_dma_one_irq: assert property (
    (st_r == ST_DMA) ##1 (st_r == ST_SECT) && !dma_end |=> !$rose(intrq_r))
    else $error("interrupt raised between sectors");
  chk_dma_end_count: assert property (
    (st_r == ST_SECT && sect_last && !disk_err)
    |=> tf_r.sector_count_field == 8'h00
    && $stable(tf_r.sector_number_field) && intrq_r && !bsy_r)
    else $error("dma end count or address wrong");
  chk_err_addr: assert property (
    (st_r == ST_SECT && disk_err) |=> err_r && $stable(tf_r) && !bsy_r)
    else $error("error end moved address");
  chk_sleep_hold: assert property (
    (pm_r == PM_SLEEP && !srst) |=> pm_r == PM_SLEEP)
    else $error("left sleep without reset");
  chk_ready_bit: assert property (
    (psel && penable && !pready_r && paddr == OFS_STAT
     && pm_r != PM_SLEEP) |=> prdata_r[STAT_DRDY])
    else $error("ready bit low while awake");
  chk_timer_expire: assert property (
    tmr_expire |=> pm_r == PM_STBY && !spindle_r)
    else $error("timer expiry missed standby");
  chk_chk_pwr: assert property (
    (pc == PC_CHK) |=> tf_r.sector_count_field
    == ($past(pm_r) == PM_IDLE ? 8'hff : 8'h00))
    else $error("check power result wrong");
  chk_rdbuf_seq: assert property (
    go_rdb |=> bsy_r && !drq_r ##1 !bsy_r && drq_r && intrq_r)
    else $error("read buffer sequence wrong");
  chk_idle_irq: assert property (
    ((pc == PC_IDI) && pm_r != PM_IDLE) |=> !intrq_r || $past(intrq_r))
    else $error("idle immediate interrupt before idle");
  chk_sbi_irq: assert property (
    (pc == PC_SBI) |=> intrq_r && pm_r == PM_STBY)
    else $error("standby immediate not immediate");

  cov_dma_wake: cover property (go_wdma && pm_r == PM_STBY);
  cov_dma_done: cover property (dma_end && !disk_err);
  cov_sleep_wake: cover property (pm_r == PM_SLEEP ##1 pm_r == PM_STBY);
  cov_auto_stby: cover property (tmr_expire);
endmodule : apd_core

/* dv/apd_host_model.sv */
`timescale 1ns/1ps
module apd_host_model import apd_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic armed,
  input wire logic slow,
  input wire logic dmarq,
  input wire logic spindle_on,
  output apd_dma_t dma_out,
  output logic spin_ready,
  output logic [15:0] n_beats
);
  logic [3:0] spin_r;
  logic go;
  // channel acts only once the host has set it up
  always @(posedge clk_sys) begin
    go = armed && dmarq && (!slow || $urandom_range(1) == 1);
    if (rst) begin
      dma_out <= '0;
      n_beats <= '0;
    end else begin
      // a beat counts only while the request was up
      if (dma_out.ack && dma_out.wr && dmarq) begin
        n_beats <= n_beats + 16'h0001;
      end
      dma_out.ack <= go;
      dma_out.wr <= go;
      // released data toggles so a stale word never looks valid
      dma_out.data <= go ? dma_out.data + 16'h0001 : ~dma_out.data;
    end
  end
  // motor needs a few cycles to reach speed
  always @(posedge clk_sys) begin
    if (rst || !spindle_on) begin
      spin_r <= 4'h0;
    end else if (spin_r != 4'hf) begin
      spin_r <= spin_r + 4'h1;
    end
  end
  assign spin_ready = spin_r[3];
endmodule : apd_host_model

/* dv/apd_core_tb.sv */
`timescale 1ns/1ps
module apd_core_tb import apd_pkg::*; ;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  apd_dma_t dma;
  logic dmarq, spin_ready, disk_err, spindle_on, intrq, armed, slow, irq_q;
  logic [15:0] n_beats;
  logic [15:0] bufm [256];
  int n_fail = 0, n_checks = 0, n_irq = 0;
  logic [7:0] pc [2][6] = '{'{8'he0, 8'he1, 8'he2, 8'he3, 8'he5, 8'he6},
    '{8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99}};
  apd_core #(.SEC_CYCLES(100)) apd_core_inst (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_in(dma), .dmarq(dmarq), .spin_ready(spin_ready),
    .disk_err(disk_err), .spindle_on(spindle_on), .intrq(intrq));
  apd_host_model apd_host_model_inst (.clk_sys(clk_sys), .rst(rst),
    .armed(armed), .slow(slow), .dmarq(dmarq), .spindle_on(spindle_on),
    .dma_out(dma), .spin_ready(spin_ready), .n_beats(n_beats));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    irq_q <= intrq;
    if (intrq === 1'b1 && irq_q !== 1'b1) n_irq++;
  end
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no fixed latency assumed; pready or the 50-cycle bound ends the wait
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 50) n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic cmd(input logic [7:0] op);
    wr(OFS_CMD, {24'h0, op});
  endtask : cmd
  task automatic wirq(output logic [31:0] s);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk_sys);
      if (intrq === 1'b1) break;
    end
    if (i == 20000) n_fail++;
    rd(OFS_STAT, s);
  endtask : wirq
  task automatic pmode(input logic [1:0] m);
    logic [31:0] g;
    rd(OFS_PWR, g);
    chk({30'h0, g[13:12]}, {30'h0, m});
  endtask : pmode
  // a tick may land between command and read, so one second less is fine
  task automatic chk_pwr(input logic [1:0] m, input logic [11:0] t);
    logic [31:0] g, x;
    rd(OFS_PWR, g);
    x = {16'h0, 2'b10, m, t};
    if (g[11:0] === t - 12'h001) x[11:0] = t - 12'h001;
    chk(g, x);
  endtask : chk_pwr
  task automatic set_addr(input logic [23:0] x);
    wr(OFS_SECTOR_NUMBER, {24'h0, x[7:0]});
    wr(OFS_CYL, {16'h0, x[23:8]});
    wr(OFS_HEAD, {28'h0, 4'($urandom)});
  endtask : set_addr
  task automatic addr_chk(input logic [23:0] x);
    logic [31:0] s, c;
    rd(OFS_SECTOR_NUMBER, s);
    rd(OFS_CYL, c);
    chk({8'h0, c[15:0], s[7:0]}, {8'h0, x});
  endtask : addr_chk
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    stop_test;
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic [7:0] n;
    logic [23:0] a0;
    int j, k, b0;
    clk_sys = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    disk_err = 1'b0;
    armed = 1'b0;
    slow = 1'b0;
    k = $urandom(68);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chk_pwr(2'd0, 12'd2700);
    rd(OFS_STAT, q);
    chk(q & 32'hc9, 32'h40);
    apb(1'b0, 8'hfc, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    for (j = 0; j < 2; j++) begin
      cmd(pc[j][4]);
      wirq(q);
      rd(OFS_SECTOR_COUNT, q);
      chk(q, 32'hff);
      cmd(pc[j][0]);
      wirq(q);
      pmode(2'd1);
      cmd(pc[j][4]);
      wirq(q);
      rd(OFS_SECTOR_COUNT, q);
      chk(q, 32'h0);
      cmd(pc[j][1]);
      wirq(q);
      pmode(2'd0);
      n = 8'($urandom_range(255, 1));
      wr(OFS_SECTOR_COUNT, {24'h0, n});
      cmd(pc[j][3]);
      wirq(q);
      chk_pwr(2'd0, 12'(n * 5));
      wr(OFS_SECTOR_COUNT, 32'h0);
      cmd(pc[j][2]);
      wirq(q);
      chk_pwr(2'd1, 12'd2700);
      cmd(pc[j][5]);
      wirq(q);
      pmode(2'd2);
      cmd(pc[j][4]);
      repeat (20) @(posedge clk_sys);
      chk({31'h0, intrq}, 32'h0);
      wr(OFS_CTRL, 32'h4);
      pmode(2'd1);
      cmd(pc[j][1]);
      wirq(q);
      pmode(2'd0);
    end
    wr(OFS_SECTOR_COUNT, 32'h1);
    cmd(8'he3);
    wirq(q);
    repeat (800) @(posedge clk_sys);
    pmode(2'd1);
    chk({31'h0, spindle_on}, 32'h0);
    n = 8'($urandom_range(255, 1));
    wr(OFS_SECTOR_COUNT, {24'h0, n});
    cmd(8'he2);
    wirq(q);
    a0 = 24'($urandom);
    set_addr(a0);
    wr(OFS_SECTOR_COUNT, 32'h2);
    armed <= 1'b1;
    slow <= 1'b1;
    k = n_irq;
    b0 = n_beats;
    cmd(8'hca);
    // spindle flop updates on the accepting edge; look one edge later
    @(posedge clk_sys);
    chk({31'h0, spindle_on}, 32'h1);
    rd(OFS_STAT, q);
    chk({31'h0, |(q & 32'h88)}, 32'h1);
    wirq(q);
    chk(32'(n_irq - k), 32'h1);
    chk(32'(n_beats - b0), 32'd512);
    rd(OFS_SECTOR_COUNT, q);
    chk(q, 32'h0);
    addr_chk(a0 + 24'h1);
    chk_pwr(2'd0, 12'(n * 5));
    a0 = 24'($urandom);
    set_addr(a0);
    wr(OFS_SECTOR_COUNT, 32'h3);
    slow <= 1'b0;
    disk_err <= 1'b1;
    cmd(8'hcb);
    wirq(q);
    disk_err <= 1'b0;
    chk(q & 32'h1, 32'h1);
    addr_chk(a0);
    cmd(OP_WRBUF);
    rd(OFS_STAT, q);
    chk(q & 32'h88, 32'h08);
    for (k = 0; k < SECT_WORDS; k++) begin
      bufm[k] = 16'($urandom);
      wr(OFS_DATA, {16'h0, bufm[k]});
    end
    cmd(OP_RDBUF);
    wirq(q);
    chk(q & 32'h88, 32'h08);
    for (k = 0; k < SECT_WORDS; k++) begin
      rd(OFS_DATA, q);
      chk({16'h0, q[15:0]}, {16'h0, bufm[k]});
    end
    rd(OFS_STAT, q);
    chk(q & 32'h88, 32'h0);
    stop_test;
  end
endmodule : apd_core_tb
